// ### rtl/encoder_count_output_logic.sv
// encoder counting, interpolation and regenerated quadrature outputs
`include "enc_out_defs.svh"
// Overview of operation
// - count every edge of both phases, four counts per line
// - only quadrature waveforms reach the output pins, never counts
// - unbuffered outputs pass raw encoder pins through one register, one cycle late
// - output mode input selects buffered, interpolated or divided
// - buffered incremental output is a filtered copy, same cycles per rev
// - interpolated with incremental encoder equals buffered
// - divided incremental output reduces lines by the divisor
// - sine/cosine cycles subdivide into up to 1024 counts
// - buffered sine/cosine output squares the analog cycle
// - interpolated output follows the factor; below four refused, four equals buffered
// - divided sine/cosine edge rate is factor over divisor
// - internal position uses the interpolation factor, never the divisor
// - forward/reverse pulse counts only while the opposite input is low
// - auxiliary counts four per cycle quad, one per pulse in step/dir and fwd/rev, none when off
module encoder_count_output_logic #(
  parameter int DIV_W = 12
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire enc_out_pkg::quad_s MOTOR_ENC_I,
  input wire logic SINCOS_SEL_I,
  input wire logic [9:0] SINCOS_PHASE_I,
  input wire enc_out_pkg::out_mode_e OUT_MODE_I,
  input wire logic [11:0] INTERP_I,
  input wire logic [DIV_W-1:0] DIVISOR_I,
  input wire enc_out_pkg::aux_mode_e AUX_MODE_I,
  input wire enc_out_pkg::quad_s AUX_ENC_I,
  output enc_out_pkg::quad_s UNBUF_O,
  output enc_out_pkg::quad_s BUF_O,
  output enc_out_pkg::pos_t POSITION_O,
  output enc_out_pkg::pos_t AUX_POSITION_O,
  output logic INTERP_ERR_O
);
  import enc_out_pkg::*;

  // ==========================================================
  // input synchronisation and decoding
  quad_s mot_sync;
  quad_s aux_sync;
  logic mot_step;
  logic mot_up;
  logic aux_step;
  logic aux_up;
  logic [9:0] ph_s1_reg;
  logic [9:0] ph_s2_reg;
  logic [9:0] ph_prev_reg;

  quad_decode u_mot (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pins_i(MOTOR_ENC_I),
    .sync_o(mot_sync),
    .step_o(mot_step),
    .up_o(mot_up)
  );
  quad_decode u_aux (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pins_i(AUX_ENC_I),
    .sync_o(aux_sync),
    .step_o(aux_step),
    .up_o(aux_up)
  );

  // phase word from the sine/cosine converter, synchronised
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ph_s1_reg <= '0;
      ph_s2_reg <= '0;
      ph_prev_reg <= '0;
    end else begin
      ph_s1_reg <= SINCOS_PHASE_I;
      ph_s2_reg <= ph_s1_reg;
      ph_prev_reg <= ph_s2_reg;
    end
  end

  // ==========================================================
  // interpolation factor check
  logic interp_ok;
  logic [11:0] interp_eff;
  logic [10:0] fine_cur;
  logic [10:0] fine_prev;
  logic fine_step;
  logic fine_up;
  assign interp_ok = (INTERP_I >= `MIN_INTERP) && (INTERP_I <= `MAX_INTERP);
  assign interp_eff = interp_ok ? INTERP_I : `MIN_INTERP;

  // scale phase to the selected factor: count index within the cycle
  function automatic logic [10:0] scale(input logic [9:0] ph, input logic [11:0] n);
    logic [21:0] p;
    p = 22'(ph) * 22'(n);
    return p[20:10];
  endfunction
  assign fine_cur = scale(ph_s2_reg, interp_eff);
  assign fine_prev = scale(ph_prev_reg, interp_eff);
  assign fine_step = SINCOS_SEL_I && (fine_cur != fine_prev);
  // short-way direction: modulo-cycle phase change below half a cycle is forward, wrap included
  assign fine_up = (10'(ph_s2_reg - ph_prev_reg) < 10'h200);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      INTERP_ERR_O <= 1'b0;
    end else begin
      INTERP_ERR_O <= ~interp_ok;
    end
  end

  // ==========================================================
  // motor position count
  logic cnt_step;
  logic cnt_up;
  pos_t pos_reg;
  assign cnt_step = SINCOS_SEL_I ? fine_step : mot_step;
  assign cnt_up = SINCOS_SEL_I ? fine_up : mot_up;
  // divisor never enters this count
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pos_reg <= `POS_RESET;
    end else if (cnt_step) begin
      pos_reg <= cnt_up ? pos_reg + 32'h1 : pos_reg - 32'h1;
    end
  end
  assign POSITION_O = pos_reg;

  // ==========================================================
  // output regeneration
  logic [1:0] gray_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_eff;
  logic gen_step;
  logic gen_up;
  logic src_step;
  logic src_up;
  quad_s square;
  assign div_eff = (DIVISOR_I == '0) ? DIV_W'(1) : DIVISOR_I;
  // sine/cosine squared: quadrant of the phase word
  assign square.a = ph_s2_reg[9] ~^ ph_s2_reg[8];
  assign square.b = ~ph_s2_reg[9];
  // interpolated edges drive the generator, motor edges when incremental; buffered rate is four per cycle
  assign src_step = SINCOS_SEL_I ? fine_step : mot_step;
  assign src_up = SINCOS_SEL_I ? fine_up : mot_up;
  assign gen_step = src_step && (div_cnt_reg == div_eff - DIV_W'(1));

  // divide input edges down, one output state per divisor edges
  always_ff @(posedge CLK_I) begin
    if (RST_I || OUT_MODE_I != OUT_DIVIDED) begin
      div_cnt_reg <= '0;
    end else if (src_step) begin
      div_cnt_reg <= gen_step ? '0 : div_cnt_reg + DIV_W'(1);
    end
  end
  assign gen_up = src_up;

  // gray state generator keeps phases in quadrature
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      gray_reg <= 2'h0;
    end else if (OUT_MODE_I == OUT_DIVIDED ? gen_step : (SINCOS_SEL_I && fine_step)) begin
      gray_reg <= gen_up ? gray_reg + 2'h1 : gray_reg - 2'h1;
    end
  end

  // output mux: only quadrature waveforms, never counts
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BUF_O <= '0;
      UNBUF_O <= '0;
    end else begin
      UNBUF_O <= MOTOR_ENC_I;
      case (OUT_MODE_I)
        OUT_DIVIDED: begin
          BUF_O <= '{a: gray_reg[1] ^ gray_reg[0], b: gray_reg[1]};
        end
        OUT_INTERP: begin
          if (SINCOS_SEL_I && interp_eff != `MIN_INTERP) begin
            BUF_O <= '{a: gray_reg[1] ^ gray_reg[0], b: gray_reg[1]};
          end else begin
            BUF_O <= SINCOS_SEL_I ? square : mot_sync;
          end
        end
        default: begin
          BUF_O <= SINCOS_SEL_I ? square : mot_sync;
        end
      endcase
    end
  end

  // ==========================================================
  // auxiliary counter
  logic a_prev_reg;
  logic aux_cnt;
  logic aux_dir;
  pos_t aux_reg;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      a_prev_reg <= 1'b0;
    end else begin
      a_prev_reg <= aux_sync.a;
    end
  end
  // per-mode count and direction
  always_comb begin
    aux_cnt = 1'b0;
    aux_dir = 1'b1;
    case (AUX_MODE_I)
      AUX_QUAD: begin
        aux_cnt = aux_step;
        aux_dir = aux_up;
      end
      AUX_STEP_DIR: begin
        aux_cnt = aux_sync.a & ~a_prev_reg;
        aux_dir = ~aux_sync.b;
      end
      AUX_FWD_REV: begin
        // forward pulse on phase a, reverse on phase b
        aux_cnt = (aux_step && aux_sync.a && !aux_sync.b && !a_prev_reg) ||
                  (aux_step && aux_sync.b && !aux_sync.a && a_prev_reg == aux_sync.a);
        aux_dir = aux_sync.a;
      end
      default: begin
        aux_cnt = 1'b0;
      end
    endcase
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      aux_reg <= `POS_RESET;
    end else if (aux_cnt) begin
      aux_reg <= aux_dir ? aux_reg + 32'h1 : aux_reg - 32'h1;
    end
  end
  assign AUX_POSITION_O = aux_reg;

  // ==========================================================
  // checks
  chk_unbuf_pass: assert property (@(posedge CLK_I) disable iff (RST_I)
    UNBUF_O == $past(MOTOR_ENC_I)) else $error("unbuffered output not passed through");
  chk_pos_up: assert property (@(posedge CLK_I) disable iff (RST_I)
    cnt_step && cnt_up |=> pos_reg == $past(pos_reg) + 32'h1) else $error("position did not increment");
  chk_pos_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !cnt_step |=> $stable(pos_reg)) else $error("position moved without an edge");
  chk_interp_err: assert property (@(posedge CLK_I) disable iff (RST_I)
    INTERP_I < `MIN_INTERP ##1 $stable(INTERP_I) |-> INTERP_ERR_O) else $error("low factor not refused");
  chk_buf_copy: assert property (@(posedge CLK_I) disable iff (RST_I)
    OUT_MODE_I == OUT_BUFFERED && !SINCOS_SEL_I |=> BUF_O == $past(mot_sync)) else $error("buffered copy wrong");
  chk_fwd_inhibit: assert property (@(posedge CLK_I) disable iff (RST_I)
    AUX_MODE_I == AUX_FWD_REV && aux_sync.a && aux_sync.b |=> $stable(aux_reg)) else $error("pulse counted while blocked");
  chk_aux_quad: assert property (@(posedge CLK_I) disable iff (RST_I)
    AUX_MODE_I == AUX_QUAD && aux_step && !aux_up |=> aux_reg == $past(aux_reg) - 32'h1) else $error("aux down count wrong");
  chk_div_state: assert property (@(posedge CLK_I) disable iff (RST_I)
    OUT_MODE_I == OUT_DIVIDED && !gen_step |=> $stable(gray_reg)) else $error("divided output moved early");
endmodule

// ### include/enc_out_defs.svh
// constants for the encoder count and output logic
`ifndef ENC_OUT_DEFS_SVH
`define ENC_OUT_DEFS_SVH
`define MIN_INTERP 12'h004
`define MAX_INTERP 12'h400
`define AUX_MAX_FREQ_KHZ 2500
`define CLK_FREQ_KHZ 100000
`define POS_RESET 32'h0000_0000
`endif

// ### include/enc_out_pkg.sv
// types shared by the encoder count and output logic
package enc_out_pkg;
  typedef enum logic [1:0] {OUT_BUFFERED, OUT_INTERP, OUT_DIVIDED, OUT_RSVD} out_mode_e;
  typedef enum logic [1:0] {AUX_QUAD, AUX_STEP_DIR, AUX_FWD_REV, AUX_OFF} aux_mode_e;
  typedef struct packed {
    logic a;
    logic b;
  } quad_s;
  typedef logic [31:0] pos_t;
endpackage

// ### rtl/quad_decode.sv
// synchronised quadrature step decoder
module quad_decode (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire enc_out_pkg::quad_s pins_i,
  output enc_out_pkg::quad_s sync_o,
  output logic step_o,
  output logic up_o
);
  import enc_out_pkg::*;
  quad_s s1_reg;
  quad_s s2_reg;
  quad_s prev_reg;
  // two-stage synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg <= pins_i;
      s2_reg <= s1_reg;
      prev_reg <= s2_reg;
    end
  end
  assign sync_o = s2_reg;
  // any edge of either phase counts
  assign step_o = (s2_reg.a ^ prev_reg.a) | (s2_reg.b ^ prev_reg.b);
  // gray order: a xor previous b gives direction
  assign up_o = s2_reg.a ^ prev_reg.b;
endmodule

// ### testbench/enc_model.sv
// quadrature encoder model driving the motor and auxiliary pins
module enc_model (
  input wire logic clk_i,
  output enc_out_pkg::quad_s motor_o,
  output enc_out_pkg::quad_s aux_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import enc_out_pkg::*;

  // ==========================================
  // pin drive
  // start idle, both phases low
  initial begin
    motor_o = '0;
    aux_o = '0;
  end

  // gray steps, a leads b going up; each state held 4 cycles
  task automatic move(input logic on_aux, input logic up, input int n);
    quad_s q;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      q = on_aux ? aux_o : motor_o;
      q = up ? quad_s'({~q.b, q.a}) : quad_s'({q.b, ~q.a});
      if (on_aux) begin
        aux_o = q;
      end else begin
        motor_o = q;
      end
      repeat (3) @(negedge clk_i);
    end
  endtask

  // set b level, then one pulse on a; levels held past setup
  task automatic pulse(input logic b_level);
    @(negedge clk_i);
    aux_o.b = b_level;
    repeat (4) @(negedge clk_i);
    aux_o.a = 1'b1;
    repeat (4) @(negedge clk_i);
    aux_o.a = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the encoder count and output logic
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import enc_out_pkg::*;
  logic clk;
  logic rst;
  out_mode_e out_mode;
  logic [11:0] interp;
  logic [11:0] divisor;
  aux_mode_e aux_mode;
  quad_s motor;
  quad_s aux;
  quad_s unbuf;
  quad_s buf_out;
  quad_s buf_prev;
  pos_t pos;
  pos_t aux_pos;
  logic interp_err;
  logic sincos_sel;
  logic [9:0] phase;
  int errors;
  int num_checks;
  int edges;
  pos_t base;
  logic [11:0] ftab [4] = '{12'h002, 12'h400, 12'h401, 12'h004};
  logic etab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  // ==========================================
  // clock and parts
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  enc_model model (.clk_i(clk), .motor_o(motor), .aux_o(aux));

  encoder_count_output_logic dut (
    .CLK_I(clk), .RST_I(rst), .MOTOR_ENC_I(motor), .SINCOS_SEL_I(sincos_sel), .SINCOS_PHASE_I(phase),
    .OUT_MODE_I(out_mode), .INTERP_I(interp), .DIVISOR_I(divisor), .AUX_MODE_I(aux_mode),
    .AUX_ENC_I(aux), .UNBUF_O(unbuf), .BUF_O(buf_out), .POSITION_O(pos), .AUX_POSITION_O(aux_pos),
    .INTERP_ERR_O(interp_err)
  );

  // counts regenerated output state changes
  always @(posedge clk) begin
    if (buf_out !== buf_prev) edges++;
    buf_prev <= buf_out;
  end

  // ==========================================
  // checking and closing
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one full analog cycle of phase in 32 steps, then edge and count checks
  task automatic sweep(input out_mode_e m, input int exp_edges, input string what);
    out_mode = m;
    repeat (6) @(negedge clk);
    edges = 0;
    base = pos;
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      phase = phase + 10'h020;
      repeat (3) @(negedge clk);
    end
    repeat (6) @(negedge clk);
    chk(what, edges, exp_edges);
    chk("sincos position", pos, base + 32'd8);
  endtask

  // ==========================================
  // test sequence
  initial begin
    errors = 0;
    num_checks = 0;
    edges = 0;
    rst = 1'b1;
    out_mode = OUT_BUFFERED;
    interp = 12'h004;
    divisor = 12'h001;
    aux_mode = AUX_QUAD;
    sincos_sel = 1'b0;
    phase = 10'h000;
    repeat (20) @(negedge clk);
    chk("reset position", pos, 32'h0000_0000);
    rst = 1'b0;
    // both edges of both phases, then reverse
    model.move(1'b0, 1'b1, 8);
    repeat (6) @(negedge clk);
    chk("forward count", pos, 32'h0000_0008);
    model.move(1'b0, 1'b0, 3);
    repeat (6) @(negedge clk);
    chk("reverse count", pos, 32'h0000_0005);
    chk("unbuffered", 32'(unbuf), 32'(motor));
    chk("buffered", 32'(buf_out), 32'(motor));
    $display("test count and buffered done");
    out_mode = OUT_INTERP;
    model.move(1'b0, 1'b1, 4);
    repeat (6) @(negedge clk);
    chk("interp equals buffered", 32'(buf_out), 32'(motor));
    $display("test interpolated done");
    out_mode = OUT_DIVIDED;
    divisor = 12'h002;
    repeat (4) @(negedge clk);
    edges = 0;
    base = pos;
    model.move(1'b0, 1'b1, 8);
    repeat (6) @(negedge clk);
    chk("divided edges", edges, 32'd4);
    chk("position ignores divisor", pos, base + 32'd8);
    $display("test divided done");
    for (int i = 0; i < 4; i++) begin
      interp = ftab[i];
      repeat (3) @(negedge clk);
      chk("factor refusal", 32'(interp_err), 32'(etab[i]));
    end
    $display("test factor range done");
    sincos_sel = 1'b1;
    interp = 12'h008;
    sweep(OUT_INTERP, 8, "interp edges");
    sweep(OUT_BUFFERED, 4, "square edges");
    sweep(OUT_DIVIDED, 4, "sincos divided edges");
    sincos_sel = 1'b0;
    $display("test sine cosine done");
    model.move(1'b1, 1'b1, 4);
    repeat (6) @(negedge clk);
    chk("aux quad", aux_pos, 32'h0000_0004);
    aux_mode = AUX_STEP_DIR;
    model.pulse(1'b0);
    model.pulse(1'b0);
    model.pulse(1'b1);
    repeat (6) @(negedge clk);
    chk("aux step dir", aux_pos, 32'h0000_0005);
    aux_mode = AUX_FWD_REV;
    model.pulse(1'b0);
    model.pulse(1'b1);
    repeat (6) @(negedge clk);
    chk("aux fwd rev", aux_pos, 32'h0000_0005);
    $display("test auxiliary done");
    end_of_test();
  end
endmodule
